// ---- design/pms_map.svh ----
// offsets, field positions and timing counts of the management link
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

// frame layout
`define PMS_PRE_ONES      6'h20
`define PMS_OP_READ       2'h2
`define PMS_OP_WRITE      2'h1
`define PMS_TA_WRITE      2'h2
`define PMS_FRAME_LAST    6'h3f
`define PMS_DRIVE_LAST    6'h2d
`define PMS_TA_ZERO_BIT   6'h2f
`define PMS_DATA_FIRST    6'h30
`define PMS_LAST_DATA_CNT 5'h0f

// device register indices
`define PMS_REG_EXT_CTRL  5'h0d
`define PMS_REG_EXT_DATA  5'h0e
`define PMS_REG_IRQ       5'h1b
`define PMS_REG_PHY_CTRL  5'h1f
`define PMS_IRQ_POL_BIT   14
`define PMS_EXT_FN_ADDR   2'h0
`define PMS_EXT_FN_INC    1

// controller registers, byte addresses
`define PMS_CSR_CMD       5'h00
`define PMS_CSR_STATUS    5'h04
`define PMS_CSR_RDATA     5'h08
`define PMS_CSR_IRQ_ST    5'h0c
`define PMS_CSR_IRQ_MASK  5'h10
`define PMS_CSR_CFG       5'h14
`define PMS_CMD_READ_BIT  26
`define PMS_IRQ_DONE      0
`define PMS_IRQ_DEV       1

// half period of the generated link clock in system cycles
`define PMS_MDC_HALF      8'h0d

`endif

// ---- design/pms_pkg.sv ----
// receiver state type of the device end of the management serial link
package pms_pkg;
    typedef enum logic [2:0] {
        RX_PREAMBLE,
        RX_START,
        RX_OPCODE,
        RX_ADDRESS,
        RX_TURNAROUND,
        RX_DATA
    } pms_rx_state_type;
endpackage

// ---- design/pms_link_if.sv ----
// two-wire management link: controller clock, shared data line, interrupt line
`timescale 1ns/1ps
interface pms_link_if;
    logic mdc;
    logic ctl_data_out;
    logic ctl_data_oe;
    logic dev_data_out;
    logic dev_data_oe;
    logic irq_line;
    logic data_line;

    // pulled-up shared line; whoever enables drives it, the controller if both enable
    assign data_line = ctl_data_oe ? ctl_data_out : (dev_data_oe ? dev_data_out : 1'b1);

    modport device (
        input  mdc,
        input  data_line,
        output dev_data_out,
        output dev_data_oe,
        output irq_line
    );

    modport controller (
        output mdc,
        input  data_line,
        output ctl_data_out,
        output ctl_data_oe,
        input  irq_line
    );
endinterface

// ---- design/pms_device.sv ----
// management serial slave with register space, extended window and interrupt pin
//
// Summary of operation
// - two wires: controller clock, shared data line
// - address taken from three strap inputs
// - thirty-two directly addressable sixteen-bit registers
// - window registers reach extended register space
// - address zero is unique, never broadcast
// - controller writes each device separately
// - preamble, start, opcode, addresses, turnaround, data
// - read releases turnaround; write drives turnaround
// - interrupt pin flags enabled status updates
// - upper byte enables each interrupt condition
// - lower byte records occurred conditions
// - reading interrupt register clears status afterwards
// - control bit picks interrupt pin polarity
// - interrupt pin active low after reset
`timescale 1ns/1ps
`include "pms_map.svh"

module pms_device import pms_pkg::*; #(
    parameter int EXT_WORDS = 16
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // link to the controller
    pms_link_if.device      link,
    // straps and events
    input  wire logic [2:0] device_address_straps,
    input  wire logic [7:0] irq_events,
    // configuration seen by the rest of the device
    output logic            irq_active_high
);
    localparam int EXT_AW = $clog2(EXT_WORDS);

    logic             mdc_s1_q, mdc_s2_q, mdc_s3_q;
    logic             dat_s1_q, dat_s2_q;
    logic [2:0]       strap_s1_q, strap_s2_q, strap_q;
    logic             strap_taken_q;
    logic [1:0]       strap_fill_q;
    pms_rx_state_type state_q;
    logic [5:0]       ones_q;
    logic [4:0]       cnt_q;
    logic [1:0]       op_q;
    logic [9:0]       addr_q;
    logic [15:0]      shift_q;
    logic             out_q, oe_q;
    logic [15:0]      regs_q [32];
    logic [7:0]       irq_en_q, irq_st_q;
    logic [15:0]      ext_addr_q;
    logic [15:0]      ext_mem_q [EXT_WORDS];
    logic             irq_pin_q;
    logic             rise, bit_in, match, is_read, is_write;
    logic             rd_take, wr_commit;
    logic [4:0]       reg_sel;
    logic [15:0]      wr_data, rd_val;
    logic [1:0]       ext_fn;
    logic             ext_access;

    // link clock and data are foreign to clk: two flops before use
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mdc_s1_q <= 1'b0;
            mdc_s2_q <= 1'b0;
            mdc_s3_q <= 1'b0;
            dat_s1_q <= 1'b1;
            dat_s2_q <= 1'b1;
        end else begin
            mdc_s1_q <= link.mdc;
            mdc_s2_q <= mdc_s1_q;
            mdc_s3_q <= mdc_s2_q;
            dat_s1_q <= link.data_line;
            dat_s2_q <= dat_s1_q;
        end
    end

    // straps caught once the synchroniser holds them, not its reset value
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strap_s1_q    <= 3'h0;
            strap_s2_q    <= 3'h0;
            strap_q       <= 3'h0;
            strap_taken_q <= 1'b0;
            strap_fill_q  <= 2'h0;
        end else begin
            strap_s1_q   <= device_address_straps;
            strap_s2_q   <= strap_s1_q;
            strap_fill_q <= {strap_fill_q[0], 1'b1};
            if (strap_fill_q[1] && !strap_taken_q) begin
                strap_q       <= strap_s2_q;
                strap_taken_q <= 1'b1;
            end
        end
    end

    assign rise     = mdc_s2_q & ~mdc_s3_q;
    assign bit_in   = dat_s2_q;
    // exact match only, so address zero never acts as broadcast
    assign match    = (addr_q[9:5] == {2'h0, strap_q});
    assign is_read  = (op_q == `PMS_OP_READ);
    assign is_write = (op_q == `PMS_OP_WRITE);
    assign reg_sel  = addr_q[4:0];
    assign ext_fn   = regs_q[`PMS_REG_EXT_CTRL][15:14];
    assign ext_access = (reg_sel == `PMS_REG_EXT_DATA) && (ext_fn != `PMS_EXT_FN_ADDR);
    assign rd_take  = rise && state_q == RX_TURNAROUND && cnt_q == 5'h0 && is_read && match;
    assign wr_commit = rise && state_q == RX_DATA && cnt_q == `PMS_LAST_DATA_CNT
                       && is_write && match;
    assign wr_data  = {shift_q[14:0], bit_in};

    always_comb begin
        if (reg_sel == `PMS_REG_IRQ) begin
            rd_val = {irq_en_q, irq_st_q};
        end else if (ext_access) begin
            rd_val = ext_mem_q[ext_addr_q[EXT_AW-1:0]];
        end else if (reg_sel == `PMS_REG_EXT_DATA) begin
            rd_val = ext_addr_q;
        end else begin
            rd_val = regs_q[reg_sel];
        end
    end

    // frame receiver and reply driver
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= RX_PREAMBLE;
            ones_q  <= 6'h0;
            cnt_q   <= 5'h0;
            op_q    <= 2'h0;
            addr_q  <= 10'h000;
            shift_q <= 16'h0000;
            out_q   <= 1'b0;
            oe_q    <= 1'b0;
        end else if (rise) begin
            case (state_q)
                RX_PREAMBLE: begin
                    if (bit_in) begin
                        if (ones_q != `PMS_PRE_ONES) begin
                            ones_q <= ones_q + 6'h1;
                        end
                    end else begin
                        ones_q <= 6'h0;
                        if (ones_q == `PMS_PRE_ONES) begin
                            state_q <= RX_START;
                        end
                    end
                end
                RX_START: begin
                    cnt_q   <= 5'h0;
                    state_q <= bit_in ? RX_OPCODE : RX_PREAMBLE;
                end
                RX_OPCODE: begin
                    op_q  <= {op_q[0], bit_in};
                    cnt_q <= cnt_q + 5'h1;
                    if (cnt_q == 5'h1) begin
                        cnt_q   <= 5'h0;
                        state_q <= RX_ADDRESS;
                    end
                end
                RX_ADDRESS: begin
                    addr_q <= {addr_q[8:0], bit_in};
                    cnt_q  <= cnt_q + 5'h1;
                    if (cnt_q == 5'h9) begin
                        cnt_q   <= 5'h0;
                        state_q <= RX_TURNAROUND;
                    end
                end
                RX_TURNAROUND: begin
                    // first turnaround bit left to the pull-up, then our zero
                    if (cnt_q == 5'h0) begin
                        cnt_q <= 5'h1;
                        if (is_read && match) begin
                            oe_q    <= 1'b1;
                            out_q   <= 1'b0;
                            shift_q <= rd_val;
                        end
                    end else begin
                        cnt_q   <= 5'h0;
                        state_q <= RX_DATA;
                        if (oe_q) begin
                            out_q   <= shift_q[15];
                            shift_q <= {shift_q[14:0], 1'b0};
                        end
                    end
                end
                RX_DATA: begin
                    cnt_q <= cnt_q + 5'h1;
                    if (oe_q) begin
                        out_q   <= shift_q[15];
                        shift_q <= {shift_q[14:0], 1'b0};
                    end else begin
                        shift_q <= wr_data;
                    end
                    if (cnt_q == `PMS_LAST_DATA_CNT) begin
                        oe_q    <= 1'b0;
                        cnt_q   <= 5'h0;
                        state_q <= RX_PREAMBLE;
                    end
                end
                default: begin
                    state_q <= RX_PREAMBLE;
                    oe_q    <= 1'b0;
                end
            endcase
        end
    end

    // plain register storage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 32; i++) begin
                regs_q[i] <= 16'h0000;
            end
        end else if (wr_commit && reg_sel != `PMS_REG_IRQ && reg_sel != `PMS_REG_EXT_DATA) begin
            regs_q[reg_sel] <= wr_data;
        end
    end

    // extended window: address word and data with optional post-increment
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_addr_q <= 16'h0000;
            for (int i = 0; i < EXT_WORDS; i++) begin
                ext_mem_q[i] <= 16'h0000;
            end
        end else if ((wr_commit || rd_take) && reg_sel == `PMS_REG_EXT_DATA) begin
            if (!ext_access) begin
                if (wr_commit) begin
                    ext_addr_q <= wr_data;
                end
            end else begin
                if (wr_commit) begin
                    ext_mem_q[ext_addr_q[EXT_AW-1:0]] <= wr_data;
                end
                if (ext_fn[`PMS_EXT_FN_INC]) begin
                    ext_addr_q <= ext_addr_q + 16'h0001;
                end
            end
        end
    end

    // interrupt enables and sticky status; a new event beats the read clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_en_q <= 8'h00;
            irq_st_q <= 8'h00;
        end else begin
            if (wr_commit && reg_sel == `PMS_REG_IRQ) begin
                irq_en_q <= wr_data[15:8];
            end
            if (rd_take && reg_sel == `PMS_REG_IRQ) begin
                irq_st_q <= irq_events;
            end else begin
                irq_st_q <= irq_st_q | irq_events;
            end
        end
    end

    assign irq_active_high = regs_q[`PMS_REG_PHY_CTRL][`PMS_IRQ_POL_BIT];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_pin_q <= 1'b1;
        end else begin
            irq_pin_q <= (|(irq_en_q & irq_st_q)) ~^ irq_active_high;
        end
    end

    assign link.dev_data_out = out_q;
    assign link.dev_data_oe  = oe_q;
    assign link.irq_line     = irq_pin_q;
endmodule

// ---- design/pms_controller.sv ----
// management link controller with an Avalon-MM register slave
`timescale 1ns/1ps
`include "pms_map.svh"

module pms_controller import pms_pkg::*; (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    // link to the device
    pms_link_if.controller   link
);
    logic        ack_q;
    logic        acc_wr;
    logic [31:0] wmask;
    logic [1:0]  irq_st_q, irq_mask_q;
    logic [1:0]  irq_clr;
    logic        cfg_hi_q;
    logic [15:0] rdata_q;
    logic        no_answer_q;
    logic        busy_q, rd_op_q, mdc_q, out_q, oe_q, done;
    logic [7:0]  div_q;
    logic [5:0]  bit_q;
    logic [63:0] frame_q;
    logic        in_s1_q, in_s2_q, irq_s1_q, irq_s2_q, dev_irq_prev_q;
    logic        dev_irq, launch, tick;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign acc_wr = avs_write & ack_q;
    assign wmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign launch = acc_wr && avs_address == `PMS_CSR_CMD && !busy_q && |avs_byteenable;
    assign tick   = busy_q && div_q == `PMS_MDC_HALF - 8'h1;
    assign done   = tick && !mdc_q && bit_q == `PMS_FRAME_LAST;
    assign dev_irq = irq_s2_q ~^ cfg_hi_q;
    assign irq_clr = {2{acc_wr && avs_address == `PMS_CSR_IRQ_ST}}
                     & avs_writedata[1:0] & wmask[1:0];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_q        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
            if (avs_read && !ack_q) begin
                case (avs_address)
                    `PMS_CSR_STATUS:   avs_readdata <= {29'h0, no_answer_q, dev_irq, busy_q};
                    `PMS_CSR_RDATA:    avs_readdata <= {16'h0000, rdata_q};
                    `PMS_CSR_IRQ_ST:   avs_readdata <= {30'h0, irq_st_q};
                    `PMS_CSR_IRQ_MASK: avs_readdata <= {30'h0, irq_mask_q};
                    `PMS_CSR_CFG:      avs_readdata <= {31'h0, cfg_hi_q};
                    default:           avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // mask and polarity configuration
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_mask_q <= 2'h0;
            cfg_hi_q   <= 1'b0;
        end else if (acc_wr) begin
            if (avs_address == `PMS_CSR_IRQ_MASK) begin
                irq_mask_q <= (irq_mask_q & ~wmask[1:0]) | (avs_writedata[1:0] & wmask[1:0]);
            end
            if (avs_address == `PMS_CSR_CFG && avs_byteenable[0]) begin
                cfg_hi_q <= avs_writedata[0];
            end
        end
    end

    // device interrupt pin is foreign to clk
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            in_s1_q        <= 1'b1;
            in_s2_q        <= 1'b1;
            irq_s1_q       <= 1'b1;
            irq_s2_q       <= 1'b1;
            dev_irq_prev_q <= 1'b0;
        end else begin
            in_s1_q        <= link.data_line;
            in_s2_q        <= in_s1_q;
            irq_s1_q       <= link.irq_line;
            irq_s2_q       <= irq_s1_q;
            dev_irq_prev_q <= dev_irq;
        end
    end

    // sticky status, write one to clear; a same-cycle event wins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_st_q <= 2'h0;
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | {dev_irq & ~dev_irq_prev_q, done};
        end
    end

    assign irq = |(irq_st_q & irq_mask_q);

    // frame engine: data changes on clock fall, read bits sampled at rise
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_q      <= 1'b0;
            rd_op_q     <= 1'b0;
            mdc_q       <= 1'b0;
            out_q       <= 1'b1;
            oe_q        <= 1'b0;
            div_q       <= 8'h00;
            bit_q       <= 6'h00;
            frame_q     <= 64'h0000_0000_0000_0000;
            rdata_q     <= 16'h0000;
            no_answer_q <= 1'b0;
        end else if (launch) begin
            busy_q  <= 1'b1;
            rd_op_q <= avs_writedata[`PMS_CMD_READ_BIT];
            mdc_q   <= 1'b0;
            div_q   <= 8'h00;
            bit_q   <= 6'h00;
            out_q   <= 1'b1;
            oe_q    <= 1'b1;
            // one address per frame: no broadcast exists on this link
            frame_q <= {32'hFFFF_FFFF, 2'h1,
                        avs_writedata[`PMS_CMD_READ_BIT] ? `PMS_OP_READ : `PMS_OP_WRITE,
                        avs_writedata[25:16],
                        avs_writedata[`PMS_CMD_READ_BIT] ? 2'h3 : `PMS_TA_WRITE,
                        avs_writedata[15:0]};
        end else if (busy_q) begin
            div_q <= tick ? 8'h00 : div_q + 8'h1;
            if (tick) begin
                mdc_q <= ~mdc_q;
                if (!mdc_q && rd_op_q) begin
                    if (bit_q == `PMS_TA_ZERO_BIT) begin
                        no_answer_q <= in_s2_q;
                    end
                    if (bit_q >= `PMS_DATA_FIRST) begin
                        rdata_q <= {rdata_q[14:0], in_s2_q};
                    end
                end
                if (mdc_q) begin
                    if (bit_q == `PMS_FRAME_LAST) begin
                        busy_q <= 1'b0;
                        oe_q   <= 1'b0;
                        out_q  <= 1'b1;
                    end else begin
                        bit_q   <= bit_q + 6'h1;
                        frame_q <= {frame_q[62:0], 1'b0};
                        out_q   <= frame_q[62];
                        oe_q    <= !(rd_op_q && bit_q >= `PMS_DRIVE_LAST);
                    end
                end
            end
        end
    end

    assign link.mdc          = mdc_q;
    assign link.ctl_data_out = out_q;
    assign link.ctl_data_oe  = oe_q;
endmodule

// ---- tb/pms_link_props.sv ----
// concurrent checks on the management link between controller and device
`timescale 1ns/1ps
module pms_link_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // link wires
    input wire logic mdc,
    input wire logic ctl_data_out,
    input wire logic ctl_data_oe,
    input wire logic dev_data_out,
    input wire logic dev_data_oe,
    input wire logic irq_line,
    // device configuration
    input wire logic irq_active_high
);
    logic [4:0] hi_cnt_q;
    logic [4:0] lo_cnt_q;
    logic [8:0] oe_cnt_q;

    // low count saturates: idle gaps between frames are long
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hi_cnt_q <= 5'h00;
            lo_cnt_q <= 5'h00;
            oe_cnt_q <= 9'h000;
        end else begin
            hi_cnt_q <= mdc ? hi_cnt_q + 5'h01 : 5'h00;
            lo_cnt_q <= mdc ? 5'h00 : lo_cnt_q + {4'h0, lo_cnt_q != 5'h1f};
            oe_cnt_q <= dev_data_oe ? oe_cnt_q + 9'h001 : 9'h000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_reply_start;
        $rose(dev_data_oe);
    endsequence
    sequence s_line_free;
        !ctl_data_oe [*8];
    endsequence

    a_no_drive_clash: assert property (!(ctl_data_oe && dev_data_oe))
        else $error("both ends drive the data line");
    a_mdc_high_span: assert property ($fell(mdc) |-> hi_cnt_q == 5'h0d)
        else $error("link clock high phase has wrong length");
    a_mdc_low_span: assert property ($rose(mdc) |-> lo_cnt_q >= 5'h0d)
        else $error("link clock low phase too short");
    a_reply_start: assert property (s_reply_start |-> !dev_data_out ##1 s_line_free)
        else $error("reply does not open with a zero on a free line");
    a_reply_length: assert property ($fell(dev_data_oe) |->
        (oe_cnt_q >= 9'h1b8 && oe_cnt_q <= 9'h1bc))
        else $error("device drove the line for the wrong span");
    a_dev_moves_late: assert property (($changed(dev_data_out) || $changed(dev_data_oe))
        |-> mdc)
        else $error("device changed the line outside the clock high phase");
    a_ctl_moves_low: assert property (($changed(ctl_data_out) || $changed(ctl_data_oe))
        |-> !mdc)
        else $error("controller changed the line while clock high");
    a_polarity_flip: assert property ($changed(irq_active_high) |=> $changed(irq_line))
        else $error("interrupt pin ignored polarity change");
    a_reset_level: assert property ($fell(reset) |-> irq_line)
        else $error("interrupt pin not idle high after reset");
endmodule

// ---- tb/test_phy_mgmt_serial_irq.sv ----
// self-checking bench joining controller and device over the management link
`timescale 1ns/1ps
`include "pms_map.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_phy_mgmt_serial_irq;
    logic        clk;
    logic        reset;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic [2:0]  straps;
    logic [7:0]  irq_events;
    logic        irq_active_high;
    logic [31:0] rd;
    logic [31:0] st;
    logic [15:0] v;
    logic [4:0]  ra;
    logic [4:0]  p;
    int          errors;
    int          compares;
    int          seed;

    pms_link_if link ();
    pms_controller u_pms_controller (.clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .link(link));
    pms_device #(.EXT_WORDS(16)) u_pms_device (.clk(clk), .reset(reset), .link(link),
        .device_address_straps(straps), .irq_events(irq_events),
        .irq_active_high(irq_active_high));
    pms_link_props u_pms_link_props (.clk(clk), .reset(reset), .mdc(link.mdc),
        .ctl_data_out(link.ctl_data_out), .ctl_data_oe(link.ctl_data_oe),
        .dev_data_out(link.dev_data_out), .dev_data_oe(link.dev_data_oe),
        .irq_line(link.irq_line), .irq_active_high(irq_active_high));

    always #2.5 clk = ~clk;

    function automatic logic [31:0] cmd_word(input logic r, input logic [4:0] ph,
        input logic [4:0] a, input logic [15:0] d);
        return {5'h00, r, ph, a, d};
    endfunction

    function automatic logic exp_line(input logic pend, input logic pol);
        return pol ? pend : !pend;
    endfunction

    task automatic complete_run();
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            errors++;
            complete_run();
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic mgmt(input logic r, input logic [4:0] ph, input logic [4:0] a,
        input logic [15:0] d);
        int n;
        n = 0;
        av(1'b1, `PMS_CSR_CMD, cmd_word(r, ph, a, d));
        do begin
            av(1'b0, `PMS_CSR_STATUS, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b0 && n < 1000);
        if (n >= 1000) begin
            errors++;
            complete_run();
        end
        st = rd;
        av(1'b0, `PMS_CSR_RDATA, 32'h0000_0000);
    endtask

    task automatic pulse(input logic [7:0] e);
        @(posedge clk);
        irq_events <= e;
        @(posedge clk);
        irq_events <= 8'h00;
        repeat (10) @(posedge clk);
    endtask

    // straps settle during reset; first frame waits past the strap capture
    task automatic do_reset(input logic [2:0] s);
        reset <= 1'b1;
        straps <= s;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    initial begin
        seed = 78306;
        errors = 0;
        compares = 0;
        clk = 1'b0;
        reset = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        straps = 3'h0;
        irq_events = 8'h00;
        fork
            begin
                repeat (80000) @(posedge clk);
                errors++;
                complete_run();
            end
        join_none
        do_reset(3'h0);
        `CHK("reset irq_line", 1'b1, link.irq_line)
        `CHK("reset polarity", 1'b0, irq_active_high)
        av(1'b0, 5'h18, 32'h0000_0000);
        `CHK("unmapped read", 32'h0000_0000, rd)
        av(1'b1, `PMS_CSR_IRQ_MASK, 32'h0000_0003);
        mgmt(1'b0, 5'h00, `PMS_REG_IRQ, 16'h0100);
        @(negedge clk);
        `CHK("done irq", 1'b1, irq)
        av(1'b1, `PMS_CSR_IRQ_ST, 32'h0000_0003);
        @(negedge clk);
        `CHK("irq cleared", 1'b0, irq)
        pulse(8'h08);
        `CHK("masked cond", 1'b1, link.irq_line)
        pulse(8'h01);
        `CHK("enabled cond", 1'b0, link.irq_line)
        av(1'b0, `PMS_CSR_STATUS, 32'h0000_0000);
        `CHK("status irq", 1'b1, rd[1])
        `CHK("ctl irq", 1'b1, irq)
        mgmt(1'b1, 5'h00, `PMS_REG_IRQ, 16'h0000);
        `CHK("irq flags", 16'h0109, rd[15:0])
        mgmt(1'b1, 5'h00, `PMS_REG_IRQ, 16'h0000);
        `CHK("flags cleared", 16'h0100, rd[15:0])
        `CHK("line released", 1'b1, link.irq_line)
        v = 16'($random(seed)) | 16'h4000;
        mgmt(1'b0, 5'h00, `PMS_REG_PHY_CTRL, v);
        mgmt(1'b1, 5'h00, `PMS_REG_PHY_CTRL, 16'h0000);
        `CHK("ctrl reg", v, rd[15:0])
        `CHK("high polarity", 1'b1, irq_active_high)
        `CHK("idle line high pol", exp_line(1'b0, 1'b1), link.irq_line)
        av(1'b1, `PMS_CSR_CFG, 32'h0000_0001);
        pulse(8'h01);
        `CHK("active line high pol", exp_line(1'b1, 1'b1), link.irq_line)
        av(1'b0, `PMS_CSR_STATUS, 32'h0000_0000);
        `CHK("status irq high pol", 1'b1, rd[1])
        for (int i = 0; i < 2; i++) begin
            p = (i == 0) ? 5'h00 : {2'b00, 3'($random(seed)) | 3'h1};
            do_reset(p[2:0]);
            `CHK("rereset line", exp_line(1'b0, 1'b0), link.irq_line)
            ra = {2'b00, 3'($random(seed))};
            v = 16'($random(seed));
            mgmt(1'b0, p, ra, v);
            mgmt(1'b1, p, ra, 16'h0000);
            `CHK("reg readback", v, rd[15:0])
            `CHK("answered", 1'b0, st[2])
            mgmt(1'b0, (i == 0) ? 5'h08 : 5'h00, ra, ~v);
            mgmt(1'b1, p ^ 5'h04, ra, 16'h0000);
            `CHK("other addr data", 16'hffff, rd[15:0])
            `CHK("other addr silent", 1'b1, st[2])
            mgmt(1'b1, p, ra, 16'h0000);
            `CHK("no broadcast", v, rd[15:0])
        end
        mgmt(1'b0, p, `PMS_REG_EXT_CTRL, 16'h0000);
        mgmt(1'b0, p, `PMS_REG_EXT_DATA, 16'h0005);
        mgmt(1'b0, p, `PMS_REG_EXT_CTRL, 16'h4000);
        mgmt(1'b0, p, `PMS_REG_EXT_DATA, ~v);
        mgmt(1'b1, p, `PMS_REG_EXT_DATA, 16'h0000);
        `CHK("ext word", ~v, rd[15:0])
        mgmt(1'b0, p, `PMS_REG_EXT_CTRL, 16'h8000);
        mgmt(1'b1, p, `PMS_REG_EXT_DATA, 16'h0000);
        `CHK("ext incr word", ~v, rd[15:0])
        mgmt(1'b0, p, `PMS_REG_EXT_CTRL, 16'h0000);
        mgmt(1'b1, p, `PMS_REG_EXT_DATA, 16'h0000);
        `CHK("ext incr addr", 16'h0006, rd[15:0])
        complete_run();
    end
endmodule
